//--- wdl_watchdog.sv
`timescale 1ns/1ps
`include "wdl_map.svh"

// How it works
// - plain halt without options: no reset, one last decrement, then freeze.
// - leaving plain halt on external interrupt waits 256 or 4096 clocks.
// - reset ending halt disables the watchdog unless hardware option set.
// - halt with rtc irq off and halt-reset option on raises reset.
// - halt with rtc irq on enters active halt, no reset, counter held.
// - active halt left by oscillator or external interrupt resumes at once.
// - active halt left by reset resumes after 256 or 4096 clocks.
// - hardware option keeps watchdog always active, activate bit unused.
// - activate bit set only by software, cleared only by reset.
// - watchdog reset only possible while activate bit is one or hardware option set, except the halt-reset option reset and a write setting activate.
// - 7-bit counter in bits 6 to 0, read and write.
// - counter decrements once every 16384 divided oscillator cycles.
// - reset when counter rolls from 40h to 3Fh.
// - control register at 002Ah, resets to 7Fh.
// - watchdog reset pulls the reset pin low for 30 us.
// - counter runs even when disabled, stops only in halt cases and in the wake delay after any reset.
// - writing activate set with bit 6 clear forces immediate reset.

module wdl_watchdog import wdl_pkg::*; #(
    parameter int unsigned PRESC_CYCLES = `WDL_PRESC_CYCLES
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic [15:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata,
    input wire logic halt_exec,
    input wire logic rtc_irq_enable,
    input wire logic halt_reset_option,
    input wire logic hw_watchdog_option,
    input wire logic wake_delay_long,
    input wire logic ext_irq_wake,
    input wire logic osc_irq_wake,
    input wire logic reset_pin_in,
    output logic reset_pin_out,
    output logic reset_pin_oe
);

    // ------------------------------------------------------------------
    // constants
    // ------------------------------------------------------------------
    localparam logic [13:0] PRESC_LAST = 14'(PRESC_CYCLES - 1);
    localparam logic [12:0] WAKE_SHORT_LAST = 13'(`WDL_WAKE_SHORT - 1);
    localparam logic [12:0] WAKE_LONG_LAST = 13'(`WDL_WAKE_LONG - 1);
    localparam logic [7:0] CTRL_RESET = `WDL_CTRL_RESET;

    // ------------------------------------------------------------------
    // state
    // ------------------------------------------------------------------
    wdl_state_type state, next_state;
    logic activate, next_activate;
    logic [6:0] counter, next_counter;
    logic [13:0] presc, next_presc;
    logic [12:0] wake_cnt, next_wake_cnt;
    logic [7:0] next_rdata;

    logic active;
    logic tick;
    logic wr_ctrl;
    logic [12:0] wake_last;
    logic [7:0] status;

    wdl_rst_if rif ();

    // ------------------------------------------------------------------
    // reset pulse generator and pin filter
    // ------------------------------------------------------------------
    wdl_reset_pulse u_pulse (
        .clk(clk),
        .rst(rst),
        .rif(rif),
        .reset_pin_in(reset_pin_in),
        .reset_pin_out(reset_pin_out),
        .reset_pin_oe(reset_pin_oe)
    );

    // ------------------------------------------------------------------
    // decoded conditions
    // ------------------------------------------------------------------
    assign active = activate | hw_watchdog_option;
    assign tick = (presc == PRESC_LAST);
    assign wr_ctrl = reg_wr && (reg_addr == `WDL_CTRL_ADDR);
    assign wake_last = wake_delay_long ? WAKE_LONG_LAST : WAKE_SHORT_LAST;

    // status word for readback; upper bits read as zero
    always_comb begin
        status = 8'h00;
        status[`WDL_ST_HALTED] = (state == st_halt) || (state == st_ahalt);
        status[`WDL_ST_AHALT] = (state == st_ahalt);
        status[`WDL_ST_WAKE] = (state == st_wake);
        status[`WDL_ST_ACTIVE] = active;
        status[`WDL_ST_PIN] = rif.pin_level;
        status[`WDL_ST_BUSY] = rif.busy;
    end

    // ------------------------------------------------------------------
    // counter, activation, low-power sequencing
    // ------------------------------------------------------------------
    // slow and wait have no input here: they only slow the cpu, and the
    // prescaler runs off this clock whatever the cpu does
    always_comb begin
        next_state = state;
        next_activate = activate;
        next_counter = counter;
        next_presc = presc;
        next_wake_cnt = wake_cnt;
        rif.trigger = 1'b0; // the only request toward the system
        unique case (state)
            st_run: begin
                // free running prescaler, stops with the oscillator in halt
                next_presc = tick ? 14'h0000 : presc + 14'h0001;
                if (halt_exec && rtc_irq_enable) begin
                    next_state = st_ahalt; // hold, no reset
                end else if (halt_exec && halt_reset_option) begin
                    rif.trigger = 1'b1; // reset instead of halt
                end else if (halt_exec) begin
                    // one last step, trip suppressed
                    next_counter = counter - 7'h01;
                    next_state = st_halt;
                end else if (tick) begin
                    // counts even while disabled
                    next_counter = counter - 7'h01;
                    if (active && counter == `WDL_TRIP_FROM) begin
                        rif.trigger = 1'b1; // bit 6 falls
                    end
                end
            end
            st_halt: begin
                // frozen until an external interrupt or reset
                if (ext_irq_wake) begin
                    next_state = st_wake;
                    next_wake_cnt = 13'h0000;
                end
            end
            st_wake: begin
                // oscillator start-up wait, counter still held
                if (wake_cnt == wake_last) begin
                    next_state = st_run;
                    next_wake_cnt = 13'h0000;
                end else begin
                    next_wake_cnt = wake_cnt + 13'h0001;
                end
            end
            st_ahalt: begin
                // no delay on interrupt exit
                if (osc_irq_wake || ext_irq_wake) begin
                    next_state = st_run;
                end
            end
        endcase
        // software access wins over a decrement in the same cycle
        if (wr_ctrl) begin
            next_counter = reg_wdata[6:0];
            if (reg_wdata[`WDL_ACT_BIT]) begin
                next_activate = 1'b1; // writing zero never clears
            end
            // software reset: enabled and bit 6 written low
            if ((reg_wdata[`WDL_ACT_BIT] || active) && !reg_wdata[`WDL_MSB_BIT]) begin
                rif.trigger = 1'b1;
            end
        end
    end

    // ------------------------------------------------------------------
    // register readback, data valid in the cycle after the strobe
    // ------------------------------------------------------------------
    always_comb begin
        next_rdata = 8'h00;
        if (reg_rd && reg_addr == `WDL_CTRL_ADDR) begin
            next_rdata = {activate, counter};
        end else if (reg_rd && reg_addr == `WDL_STAT_ADDR) begin
            next_rdata = status;
        end
    end

    // ------------------------------------------------------------------
    // registers
    // ------------------------------------------------------------------
    // a reset always lands in the wake wait: the core cannot tell which
    // mode it came from, so every reset gets the start-up delay
    always_ff @(posedge clk) begin
        if (rst) begin
            state <= st_wake;
            activate <= CTRL_RESET[`WDL_ACT_BIT]; // disabled again
            counter <= `WDL_CNT_RESET;
            presc <= 14'h0000;
            wake_cnt <= 13'h0000;
            reg_rdata <= 8'h00;
        end else begin
            state <= next_state;
            activate <= next_activate;
            counter <= next_counter;
            presc <= next_presc;
            wake_cnt <= next_wake_cnt;
            reg_rdata <= next_rdata;
        end
    end

    // ------------------------------------------------------------------
    // checks
    // ------------------------------------------------------------------
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (rst);

    a_plain_halt_step: assert property (
        (state == st_run && halt_exec && !rtc_irq_enable && !halt_reset_option && !wr_ctrl)
        |-> !rif.trigger ##1 (state == st_halt && counter == 7'($past(counter) - 7'h01)))
        else $error("plain halt entry wrong");

    a_halt_frozen: assert property (
        (state == st_halt && !wr_ctrl) |=> counter == $past(counter))
        else $error("counter moved in halt");

    a_wake_delay: assert property (
        (state == st_wake) |=>
        ((state == st_run) == ($past(wake_cnt) == $past(wake_last))))
        else $error("wake delay length wrong");

    a_halt_opt_reset: assert property (
        (state == st_run && halt_exec && !rtc_irq_enable && halt_reset_option)
        |-> rif.trigger ##1 state == st_run)
        else $error("halt option reset missing");

    a_ahalt_entry: assert property (
        (state == st_run && halt_exec && rtc_irq_enable && !wr_ctrl)
        |-> !rif.trigger ##1 (state == st_ahalt && counter == $past(counter)))
        else $error("active halt entry wrong");

    a_ahalt_exit: assert property (
        (state == st_ahalt && (osc_irq_wake || ext_irq_wake)) |=> state == st_run)
        else $error("active halt exit delayed");

    a_act_sticky: assert property (
        activate |=> activate)
        else $error("activate bit cleared");

    a_no_trip_off: assert property (
        (!active && !(wr_ctrl && reg_wdata[`WDL_ACT_BIT])
         && !(state == st_run && halt_exec && !rtc_irq_enable && halt_reset_option))
        |-> !rif.trigger)
        else $error("reset while disabled");

    // a refresh on the rollover cycle still lands, but the reset is already on its way
    a_trip_fires: assert property (
        (state == st_run && tick && active && counter == `WDL_TRIP_FROM
         && !halt_exec && !rif.busy)
        |=> (reset_pin_oe && counter == ($past(wr_ctrl) ? 7'($past(reg_wdata)) : 7'h3F)))
        else $error("no reset at rollover");

    a_tick_step: assert property (
        (state == st_run && tick && !halt_exec && !wr_ctrl)
        |=> (counter == 7'($past(counter) - 7'h01) && presc == 14'h0000))
        else $error("counter step wrong");

    a_read_data: assert property (
        (reg_rd && reg_addr == `WDL_CTRL_ADDR) |=> reg_rdata == {$past(activate), $past(counter)})
        else $error("readback wrong");

    a_rdata_idle: assert property (
        !reg_rd |=> reg_rdata == 8'h00)
        else $error("read data outlived its cycle");

    a_ctrl_write: assert property (
        wr_ctrl |=> counter == 7'($past(reg_wdata)))
        else $error("counter write lost");

    a_act_set: assert property (
        (wr_ctrl && reg_wdata[`WDL_ACT_BIT]) |=> activate)
        else $error("activate bit not set");

    a_soft_reset: assert property (
        (wr_ctrl && (reg_wdata[`WDL_ACT_BIT] || active) && !reg_wdata[`WDL_MSB_BIT])
        |-> rif.trigger)
        else $error("software reset missing");

    a_hw_trip: assert property (
        (hw_watchdog_option && state == st_run && tick && counter == `WDL_TRIP_FROM
         && !halt_exec) |-> rif.trigger)
        else $error("hardware option did not trip");

    a_halt_wake: assert property (
        (state == st_halt && ext_irq_wake) |=> (state == st_wake && wake_cnt == 13'h0000))
        else $error("halt wake entry wrong");

    a_wake_frozen: assert property (
        (state == st_wake && !wr_ctrl) |=> counter == $past(counter))
        else $error("counter moved in wake delay");

    a_ahalt_held: assert property (
        (state == st_ahalt && !wr_ctrl) |=> counter == $past(counter))
        else $error("counter moved in active halt");

    a_presc_frozen: assert property (
        (state != st_run) |=> presc == $past(presc))
        else $error("prescaler ran outside run");

endmodule : wdl_watchdog

//--- wdl_map.svh
`ifndef WDL_MAP_SVH
`define WDL_MAP_SVH

// ----------------------------------------------------------------------
// register map
// ----------------------------------------------------------------------
`define WDL_CTRL_ADDR 16'h002A
`define WDL_STAT_ADDR 16'h002B
`define WDL_CTRL_RESET 8'h7F
`define WDL_ACT_BIT 7
`define WDL_MSB_BIT 6
`define WDL_CNT_RESET 7'h7F
`define WDL_TRIP_FROM 7'h40

// status register fields
`define WDL_ST_HALTED 0
`define WDL_ST_AHALT 1
`define WDL_ST_WAKE 2
`define WDL_ST_ACTIVE 3
`define WDL_ST_PIN 4
`define WDL_ST_BUSY 5

// ----------------------------------------------------------------------
// timing
// ----------------------------------------------------------------------
`define WDL_CLK_MHZ 40
`define WDL_PRESC_CYCLES 16384
`define WDL_RST_PULSE_US 30
`define WDL_RST_PULSE_CYC (`WDL_RST_PULSE_US * `WDL_CLK_MHZ)
`define WDL_WAKE_SHORT 256
`define WDL_WAKE_LONG 4096

`endif

//--- wdl_pkg.sv
package wdl_pkg;

    // ------------------------------------------------------------------
    // low-power tracking states, gray along run-halt-wake
    // ------------------------------------------------------------------
    typedef enum logic [1:0] {
        st_run = 2'b00,
        st_halt = 2'b01,
        st_wake = 2'b11,
        st_ahalt = 2'b10
    } wdl_state_type;

endpackage : wdl_pkg

//--- wdl_rst_if.sv
`timescale 1ns/1ps

// reset request path between the watchdog core and the pulse generator
interface wdl_rst_if;
    logic trigger;
    logic busy;
    logic pin_level;

    modport ctrl (output trigger, input busy, input pin_level);
    modport gen (input trigger, output busy, output pin_level);
endinterface : wdl_rst_if

//--- wdl_reset_pulse.sv
`timescale 1ns/1ps
`include "wdl_map.svh"

module wdl_reset_pulse import wdl_pkg::*; (
    input wire logic clk,
    input wire logic rst,
    wdl_rst_if.gen rif,
    input wire logic reset_pin_in,
    output logic reset_pin_out,
    output logic reset_pin_oe
);

    localparam logic [10:0] PULSE_LAST = 11'(`WDL_RST_PULSE_CYC - 1);

    logic busy, next_busy;
    logic [10:0] pulse_cnt, next_pulse_cnt;
    logic sync1, sync2, sync3, level, next_level;

    // ------------------------------------------------------------------
    // pulse timing and pin filter
    // ------------------------------------------------------------------
    always_comb begin
        next_busy = busy;
        next_pulse_cnt = pulse_cnt;
        next_level = (sync2 == sync3) ? sync3 : level; // two samples agree
        if (busy) begin
            if (pulse_cnt == PULSE_LAST) begin
                next_busy = 1'b0;
                next_pulse_cnt = 11'h000;
            end else begin
                next_pulse_cnt = pulse_cnt + 11'h001;
            end
        end else if (rif.trigger) begin
            next_busy = 1'b1; // requests during a pulse merge into it
            next_pulse_cnt = 11'h000;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            busy <= 1'b0;
            pulse_cnt <= 11'h000;
            sync1 <= 1'b1;
            sync2 <= 1'b1;
            sync3 <= 1'b1;
            level <= 1'b1;
        end else begin
            busy <= next_busy;
            pulse_cnt <= next_pulse_cnt;
            sync1 <= reset_pin_in;
            sync2 <= sync1;
            sync3 <= sync2;
            level <= next_level;
        end
    end

    // open drain: only ever pulls low
    assign reset_pin_out = 1'b0;
    assign reset_pin_oe = busy;
    assign rif.busy = busy;
    assign rif.pin_level = level;

    a_pulse_length: assert property (@(posedge clk) disable iff (rst)
        $fell(busy) |-> $past(pulse_cnt) == PULSE_LAST)
        else $error("reset pulse length wrong");

    a_pulse_start: assert property (@(posedge clk) disable iff (rst)
        (rif.trigger && !busy) |=> (busy && pulse_cnt == 11'h000))
        else $error("reset pulse did not start");

endmodule : wdl_reset_pulse

//--- watchdog_lowpower_control_bench.sv
`timescale 1ns/1ps

module watchdog_lowpower_control_bench;

    // ------------------------------------------------------------------
    // signals and design
    // ------------------------------------------------------------------
    // short prescaler so that a tick comes every 16 clocks
    localparam int PRESC = 16;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic [15:0] reg_addr = 16'h0000;
    logic [7:0] reg_wdata = 8'h00;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [7:0] reg_rdata;
    logic halt_exec = 1'b0;
    logic rtc_irq_enable = 1'b0;
    logic halt_reset_option = 1'b0;
    logic hw_watchdog_option = 1'b0;
    logic wake_delay_long = 1'b0;
    logic ext_irq_wake = 1'b0;
    logic osc_irq_wake = 1'b0;
    logic reset_pin_out;
    logic reset_pin_oe;
    int n_fail = 0;
    int tests_run = 0;
    logic [7:0] v0, v1, d;
    logic [15:0] hi;
    // ordinary cases: write address, write data, expected control readback
    logic [15:0] row_ad[7] = '{16'h002A, 16'h002A, 16'h002A, 16'h002A, 16'h002A,
                               16'h0029, 16'h002B};
    logic [7:0] row_wd[7] = '{8'h7F, 8'h41, 8'h3F, 8'h00, 8'h60, 8'h11, 8'hFF};
    // ignored writes: three ticks pass per row, so 60h reads 5Dh, then 5Ah
    logic [7:0] row_rd[7] = '{8'h7F, 8'h41, 8'h3F, 8'h00, 8'h60, 8'h5D, 8'h5A};

    always #12.5 clk = ~clk;

    wdl_watchdog #(.PRESC_CYCLES(PRESC)) DUT (
        .clk(clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .halt_exec(halt_exec), .rtc_irq_enable(rtc_irq_enable),
        .halt_reset_option(halt_reset_option), .hw_watchdog_option(hw_watchdog_option),
        .wake_delay_long(wake_delay_long), .ext_irq_wake(ext_irq_wake),
        .osc_irq_wake(osc_irq_wake), .reset_pin_in(reset_pin_oe ? reset_pin_out : 1'b1),
        .reset_pin_out(reset_pin_out), .reset_pin_oe(reset_pin_oe)
    );

    // ------------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------------
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        tests_run++;
        if (seen !== exp) begin
            n_fail++;
            $display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : chk

    task automatic tally_and_finish();
        $display("checks %0d, mismatches %0d", tests_run, n_fail);
        if (n_fail == 0 && tests_run > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : tally_and_finish

    task automatic reg_write(input logic [15:0] a, input logic [7:0] dat);
        @(posedge clk);
        reg_addr <= a;
        reg_wdata <= dat;
        reg_wr <= 1'b1;
        @(posedge clk);
        reg_wr <= 1'b0;
        #1;
    endtask : reg_write

    // data stands only in the cycle after the strobe edge
    task automatic reg_read(input logic [15:0] a, output logic [7:0] dat);
        @(posedge clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk);
        reg_rd <= 1'b0;
        #1;
        dat = reg_rdata;
    endtask : reg_read

    // one-cycle pulse: bit0 halt, bit1 external wake, bit2 oscillator wake
    task automatic strobe(input logic [2:0] s);
        @(posedge clk);
        {osc_irq_wake, ext_irq_wake, halt_exec} <= s;
        @(posedge clk);
        {osc_irq_wake, ext_irq_wake, halt_exec} <= 3'b000;
        #1;
    endtask : strobe

    // counter change across exactly 16 sampling edges, i.e. one tick span
    task automatic step(output logic [7:0] delta);
        logic [7:0] a, b;
        reg_read(16'h002A, a);
        repeat (14) @(posedge clk);
        reg_read(16'h002A, b);
        delta = (a - b) & 8'h7F;
    endtask : step

    // returns right after a tick so that the next few cycles are tick free
    task automatic sync_tick();
        logic [7:0] a, b;
        reg_read(16'h002A, a);
        for (int i = 0; i < 300; i++) begin
            reg_read(16'h002A, b);
            if (b !== a) break;
        end
    endtask : sync_tick

    // waits a bounded time for the pin drive, then counts its length
    task automatic pulse(input int wait_max, output logic [15:0] len);
        len = 16'h0000;
        for (int k = 0; k < wait_max && reset_pin_oe !== 1'b1; k++) begin
            @(posedge clk);
            #1;
        end
        while (reset_pin_oe === 1'b1 && len < 16'd2000) begin
            len++;
            @(posedge clk);
            #1;
        end
    endtask : pulse

    // reset, then sit out the wake delay before halting is possible
    task automatic do_reset();
        @(posedge clk);
        rst <= 1'b1;
        repeat (12) @(posedge clk);
        rst <= 1'b0;
        repeat (270) @(posedge clk);
        #1;
    endtask : do_reset

    // ------------------------------------------------------------------
    // tests
    // ------------------------------------------------------------------
    initial begin
        repeat (12) @(posedge clk);
        rst <= 1'b0;
        reg_read(16'h002A, v0);
        chk(v0, 8'h7F);
        step(d);
        chk(d, 8'h00);
        repeat (256) @(posedge clk);
        step(d);
        chk(d, 8'h01);
        reg_read(16'h0031, v0);
        chk(v0, 8'h00);
        // writes while inactive, including a pass through 40h
        for (int i = 0; i < 7; i++) begin
            sync_tick();
            reg_write(row_ad[i], row_wd[i]);
            reg_read(16'h002A, v0);
            chk(v0, row_rd[i]);
            repeat (40) @(posedge clk);
            #1;
            chk(reset_pin_oe, 1'b0);
        end
        // activation is sticky and trips on 40h to 3Fh
        sync_tick();
        reg_write(16'h002A, 8'hC1);
        reg_write(16'h002A, 8'h41);
        reg_read(16'h002A, v0);
        chk(v0, 8'hC1);
        repeat (12) @(posedge clk);
        #1;
        chk(reset_pin_oe, 1'b0);
        pulse(30, hi);
        chk(hi, 16'd1200);
        do_reset();
        reg_read(16'h002A, v0);
        chk(v0[7], 1'b0);
        reg_write(16'h002A, 8'hBF);
        pulse(3, hi);
        chk(hi, 16'd1200);
        chk(reset_pin_out, 1'b0);
        do_reset();
        @(posedge clk);
        halt_reset_option <= 1'b1;
        strobe(3'b001);
        pulse(3, hi);
        chk(hi, 16'd1200);
        @(posedge clk);
        halt_reset_option <= 1'b0;
        hw_watchdog_option <= 1'b1;
        do_reset();
        sync_tick();
        reg_write(16'h002A, 8'h41);
        pulse(40, hi);
        chk(hi, 16'd1200);
        @(posedge clk);
        hw_watchdog_option <= 1'b0;
        rtc_irq_enable <= 1'b1;
        do_reset();
        // active halt under both option values, left by both wake sources
        for (int w = 0; w < 2; w++) begin
            @(posedge clk);
            halt_reset_option <= w[0];
            sync_tick();
            reg_write(16'h002A, 8'hC5);
            strobe(3'b001);
            step(d);
            chk(d, 8'h00);
            reg_read(16'h002B, v0);
            chk(v0, 8'h1B);
            repeat (100) @(posedge clk);
            #1;
            chk(reset_pin_oe, 1'b0);
            strobe(w[0] ? 3'b100 : 3'b010);
            step(d);
            chk(d, 8'h01);
            do_reset();
        end
        @(posedge clk);
        rtc_irq_enable <= 1'b0;
        halt_reset_option <= 1'b0;
        // plain halt with the short and the long wake delay
        for (int l = 0; l < 2; l++) begin
            @(posedge clk);
            wake_delay_long <= l[0];
            sync_tick();
            reg_read(16'h002A, v0);
            strobe(3'b001);
            reg_read(16'h002A, v1);
            chk((v0 - v1) & 8'h7F, 8'h01);
            step(d);
            chk(d, 8'h00);
            strobe(3'b010);
            reg_read(16'h002B, v0);
            chk(v0, 8'h14);
            repeat (l ? 4000 : 200) @(posedge clk);
            step(d);
            chk(d, 8'h00);
            repeat (l ? 100 : 60) @(posedge clk);
            step(d);
            chk(d, 8'h01);
        end
        tally_and_finish();
    end

    // hang guard, well beyond the roughly 12k cycles the tests take
    initial begin
        #2_000_000;
        n_fail++;
        tally_and_finish();
    end

endmodule : watchdog_lowpower_control_bench
